//--- src/secure_row_defs.vh
// Offsets, field positions, codes, row layout and fuse constants of the secure row controller
`ifndef SECURE_ROW_DEFS_VH
`define SECURE_ROW_DEFS_VH

// Register byte offsets
`define OFF_MODE 12'h000
`define OFF_CTRL 12'h004
`define OFF_STAT 12'h008
`define OFF_MASK 12'h00c
`define OFF_ADDR 12'h010
`define OFF_WDATA 12'h014
`define OFF_RDATA 12'h018
`define OFF_CMD 12'h01c
`define OFF_CRC 12'h020

// Mode codes
`define MODE_BOOT 2'h0
`define MODE_TEST 2'h1
`define MODE_FW 2'h2
`define MODE_APP 2'h3

// Control bit positions
`define CTRL_LOCK_WP 0
`define CTRL_DELIVERED 1
`define CTRL_CARD_DIS 2
`define CTRL_ERASE 3

// Status and mask bit positions
`define ST_CORR 0
`define ST_DENY 1
`define ST_ERASED 2
`define ST_CRC_ERR 3

// Commands
`define CMD_READ 2'h1
`define CMD_WRITE 2'h2

// Protected row region layout, byte offsets inside the nonvolatile memory
`define NVM_AW 12
`define ROW_BASE 12'he00
`define RO_BASE 12'he00
`define RO_END 12'he20
`define WP_BASE 12'he20
`define WP_END 12'he30
`define WO_BASE 12'he30
`define WO_END 12'he50
`define CFG_BASE 12'he50
`define CFG_END 12'he60
`define APP_END 12'he00

// Fuse transfer
`define FUSE_WORDS 8
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021

`endif

//--- src/ecc_byte.v
// Per-byte single-bit corrector for nonvolatile memory reads
`timescale 1ns/1ps
module ecc_byte (
	input wire [7:0] data_in, // Stored data byte
	input wire [3:0] check_in, // Stored check bits
	output wire [7:0] data_out, // Corrected byte
	output wire corrected // A bit was repaired
);
	// Hamming syndrome over data bit positions 3,5,6,7,9,10,11,12
	function [3:0] hamming;
		input [7:0] d;
		begin
			hamming[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
			hamming[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
			hamming[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
			hamming[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
		end
	endfunction

	wire [3:0] syn;
	reg [7:0] flip;
	assign syn = hamming(data_in) ^ check_in;

	// Map syndrome to the flipped data bit
	always @* begin
		case (syn)
			4'h3: flip = 8'h01;
			4'h5: flip = 8'h02;
			4'h6: flip = 8'h04;
			4'h7: flip = 8'h08;
			4'h9: flip = 8'h10;
			4'ha: flip = 8'h20;
			4'hb: flip = 8'h40;
			4'hc: flip = 8'h80;
			default: flip = 8'h00;
		endcase
	end

	assign data_out = data_in ^ flip;
	assign corrected = (syn != 4'h0);
endmodule

//--- src/secure_row_ctrl.v
// Privileged mode control and protected nonvolatile row guard
//
// Function
// R1: Correct single-bit error per nonvolatile byte automatically
// R2: RAM or ROM parity mismatch forces reset
// R3: Boot may move to test or firmware
// R4: No return from test or firmware to boot
// R5: After delivery, test mode entry refused forever
// R6: Boot only during start-up after reset
// R7: After start-up, firmware only privileged mode
// R8: Top 512 bytes reserved, hidden from application
// R9: 32-byte area readable, never writable by application
// R10: 16-byte area writable until software locks it
// R11: 32-byte area bits set once, never cleared; test mode stores the written byte as given and so can clear them
// R12: Configuration area hidden from application, firmware allowed
// R13: Triggered card-disable blocks application start forever
// R14: Triggered application-erase wipes application nonvolatile data
// R15: Fuse copy at boot checked by CRC
// R16: Factory init area outside rows, unprotected
// R17: Boot, test, firmware form the super-system level
// R18: Refused writes leave stored content unchanged
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "secure_row_defs.vh"
module secure_row_ctrl #(
	parameter NVM_BYTES = 4096, // Nonvolatile bytes
	parameter FUSE_WORDS = `FUSE_WORDS, // Fuse words copied at boot
	parameter CARD_DIS_OPT = 1, // Card-disable option fitted
	parameter ERASE_OPT = 1 // Application-erase option fitted
) (
	input wire mclk, // System clock
	input wire resetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error
	input wire ram_parity_err, // RAM read parity mismatch
	input wire rom_parity_err, // ROM read parity mismatch
	input wire test_req, // Request entry to test mode
	input wire boot_done, // Start-up code finished
	input wire [15:0] fuse_crc_ref, // Expected fuse checksum
	input wire [15:0] fuse_data, // Fuse word at fuse_idx
	output reg [2:0] fuse_idx, // Fuse word index
	output reg [15:0] hw_cfg, // Copied hardware configuration
	output reg [1:0] cpu_mode, // Current privilege mode
	output wire super_mode, // Super-system level active
	output wire app_start_ok, // Application may start
	output reg parity_reset, // Forced reset request
	output wire irq // Level interrupt
);
	// ---------------------------------------------------------------
	// Storage and registers
	// ---------------------------------------------------------------
	reg [7:0] nvm_mem [0:NVM_BYTES-1];
	reg [3:0] chk_mem [0:NVM_BYTES-1];
	reg lock_reg;
	// Delivery and card-disable survive resetn, as blown fuses would
	reg delivered_reg = 1'b0;
	reg card_dis_reg = 1'b0;
	reg [3:0] stat_reg;
	reg [3:0] mask_reg;
	reg [11:0] addr_reg;
	reg [7:0] wdata_reg;
	reg [7:0] rdata_reg;
	reg [15:0] crc_reg;
	reg [31:0] prdata_reg;
	reg slverr_reg;
	reg [1:0] phase_reg;
	reg [11:0] erase_ptr;
	reg fuse_busy;
	reg [3:0] fuse_cnt;

	localparam PH_BOOT = 2'h0;
	localparam PH_FUSE = 2'h1;
	localparam PH_RUN = 2'h2;

	// Hamming check bits, same encoding as the corrector
	function [3:0] hamming;
		input [7:0] d;
		begin
			hamming[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
			hamming[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
			hamming[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
			hamming[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
		end
	endfunction

	// One CRC-16 step over a 16-bit word
	function [15:0] crc_step;
		input [15:0] c;
		input [15:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 16; i = i + 1)
				r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
			crc_step = r;
		end
	endfunction

	function in_range;
		input [11:0] a;
		input [11:0] lo;
		input [11:0] hi;
		begin
			in_range = (a >= lo) && (a < hi);
		end
	endfunction

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	wire privileged = (cpu_mode != `MODE_APP);
	wire in_rows = (addr_reg >= `ROW_BASE); // [R8]
	wire in_ro = in_range(addr_reg, `RO_BASE, `RO_END);
	wire in_wp = in_range(addr_reg, `WP_BASE, `WP_END);
	wire in_wo = in_range(addr_reg, `WO_BASE, `WO_END);
	wire in_cfg = in_range(addr_reg, `CFG_BASE, `CFG_END);
	// Application reaches only ro/wp/wo inside the rows [R8] [R12]
	wire rd_ok = !in_rows || privileged || in_ro || in_wp || in_wo; // [R9] [R12]
	// Below the rows, incl. factory init area, no hardware guard [R16]
	wire wr_ok = !in_rows || (cpu_mode == `MODE_TEST) ||
		(in_cfg && cpu_mode == `MODE_FW) ||
		(in_wp && !lock_reg) || in_wo; // [R9] [R10] [R12]
	wire [7:0] old_byte;
	wire corr;
	ecc_byte u_ecc (
		.data_in(nvm_mem[addr_reg]),
		.check_in(chk_mem[addr_reg]),
		.data_out(old_byte),
		.corrected(corr)
	);
	// Outside test mode, write-once bits only move from zero to one [R11]
	wire [7:0] new_byte = in_wo && cpu_mode != `MODE_TEST ? (old_byte | wdata_reg) : wdata_reg;
	wire wo_clear = in_wo && ((old_byte & ~wdata_reg) != 8'h00) && cpu_mode != `MODE_TEST;

	wire acc = psel && penable;
	wire wr_acc = acc && pwrite;
	wire cmd_go = wr_acc && paddr == `OFF_CMD;
	wire ctrl_go = wr_acc && paddr == `OFF_CTRL;
	wire do_rd = cmd_go && pwdata[1:0] == `CMD_READ;
	wire do_wr = cmd_go && pwdata[1:0] == `CMD_WRITE && phase_reg == PH_RUN;
	wire erasing = erase_ptr != 12'h000;

	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = 1'b0;
	assign super_mode = privileged; // [R17]
	// No application start while boot still holds the CPU [R6]
	assign app_start_ok = (phase_reg == PH_RUN) && (cpu_mode != `MODE_BOOT) &&
		!card_dis_reg && !erasing; // [R13]
	assign irq = |(stat_reg & mask_reg);

	// ---------------------------------------------------------------
	// Mode controller
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cpu_mode <= `MODE_BOOT; // [R6]
			phase_reg <= PH_BOOT;
		end else begin
			case (cpu_mode)
				`MODE_BOOT: begin
					if (phase_reg == PH_RUN) begin
						// Test only before delivery [R3] [R5] [R7]
						if (test_req && !delivered_reg)
							cpu_mode <= `MODE_TEST;
						else
							cpu_mode <= `MODE_FW;
					end
				end
				`MODE_FW: begin
					// Firmware hands to application; never back to boot [R4]
					if (wr_acc && paddr == `OFF_MODE && pwdata[1:0] == `MODE_APP)
						cpu_mode <= `MODE_APP;
				end
				`MODE_TEST: begin
					if (wr_acc && paddr == `OFF_MODE && pwdata[1:0] != `MODE_BOOT)
						cpu_mode <= pwdata[1:0]; // [R4]
				end
				`MODE_APP: begin
					if (wr_acc && paddr == `OFF_MODE && pwdata[1:0] == `MODE_FW)
						cpu_mode <= `MODE_FW;
				end
				default: cpu_mode <= `MODE_BOOT;
			endcase
			// Boot phase sequencing
			case (phase_reg)
				PH_BOOT: if (boot_done) phase_reg <= PH_FUSE;
				PH_FUSE: if (!fuse_busy && fuse_cnt != 4'h0) phase_reg <= PH_RUN;
				PH_RUN: phase_reg <= PH_RUN;
				default: phase_reg <= PH_BOOT;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Fuse copy with checksum
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fuse_busy <= 1'b0;
			fuse_cnt <= 4'h0;
			fuse_idx <= 3'h0;
			crc_reg <= `CRC_INIT;
			hw_cfg <= 16'h0000;
		end else if (phase_reg == PH_FUSE && fuse_cnt == 4'h0 && !fuse_busy) begin
			fuse_busy <= 1'b1;
			fuse_idx <= 3'h0;
		end else if (fuse_busy) begin
			crc_reg <= crc_step(crc_reg, fuse_data); // [R15]
			hw_cfg <= hw_cfg ^ fuse_data;
			fuse_idx <= fuse_idx + 3'h1;
			if (fuse_idx == FUSE_WORDS - 1) begin
				fuse_busy <= 1'b0;
				fuse_cnt <= 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Life-cycle bits
	// ---------------------------------------------------------------
	// One-way bits with no reset, so a later reset cannot undo them
	always @(posedge mclk) begin
		if (ctrl_go) begin
			delivered_reg <= delivered_reg | (pwdata[`CTRL_DELIVERED] & privileged); // [R5]
			if (CARD_DIS_OPT != 0)
				card_dis_reg <= card_dis_reg | pwdata[`CTRL_CARD_DIS]; // [R13]
		end
	end

	// ---------------------------------------------------------------
	// Parity reset request
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			parity_reset <= 1'b0;
		else
			parity_reset <= ram_parity_err | rom_parity_err; // [R2]
	end

	// ---------------------------------------------------------------
	// Control, status and APB registers
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lock_reg <= 1'b0;
			stat_reg <= 4'h0;
			mask_reg <= 4'h0;
			addr_reg <= 12'h000;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			prdata_reg <= 32'h0;
			erase_ptr <= 12'h000;
		end else begin
			if (wr_acc) begin
				case (paddr)
					`OFF_CTRL: begin
						// Lock is one-way; delivery and card-disable live apart
						lock_reg <= lock_reg | pwdata[`CTRL_LOCK_WP]; // [R10]
						if (ERASE_OPT != 0 && pwdata[`CTRL_ERASE])
							erase_ptr <= 12'h001; // [R14]
					end
					`OFF_MASK: mask_reg <= pwdata[3:0];
					`OFF_ADDR: addr_reg <= pwdata[11:0];
					`OFF_WDATA: wdata_reg <= pwdata[7:0];
					default: ;
				endcase
			end
			// Application erase sweep over the application space
			if (erasing)
				erase_ptr <= (erase_ptr == `APP_END) ? 12'h000 : erase_ptr + 12'h001;
			// Read data out of the memory
			if (do_rd)
				rdata_reg <= rd_ok ? old_byte : 8'h00; // [R1]
			// Sticky status: set wins over write-one clear
			stat_reg <= (stat_reg & ~((wr_acc && paddr == `OFF_STAT) ? pwdata[3:0] : 4'h0)) |
				{(phase_reg == PH_FUSE && fuse_cnt != 4'h0 && crc_reg != fuse_crc_ref),
				(erasing && erase_ptr == `APP_END),
				((do_rd && !rd_ok) || (do_wr && (!wr_ok || wo_clear))),
				(do_rd && rd_ok && corr)};
			// Read mux, loaded in setup so data stands through the access
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`OFF_MODE: prdata_reg <= {30'h0, cpu_mode};
					`OFF_CTRL: prdata_reg <= {28'h0, erasing, card_dis_reg, delivered_reg, lock_reg};
					`OFF_STAT: prdata_reg <= {28'h0, stat_reg};
					`OFF_MASK: prdata_reg <= {28'h0, mask_reg};
					`OFF_ADDR: prdata_reg <= {20'h0, addr_reg};
					`OFF_WDATA: prdata_reg <= {24'h0, wdata_reg};
					`OFF_RDATA: prdata_reg <= {24'h0, rdata_reg};
					`OFF_CRC: prdata_reg <= {16'h0, crc_reg};
					default: prdata_reg <= 32'h0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Memory writes
	// ---------------------------------------------------------------
	always @(posedge mclk) begin
		if (erasing) begin
			nvm_mem[erase_ptr - 12'h001] <= 8'h00; // [R14]
			chk_mem[erase_ptr - 12'h001] <= 4'h0;
		end else if (do_wr && wr_ok) begin
			// Refused writes leave content untouched [R18]
			nvm_mem[addr_reg] <= new_byte; // [R11]
			chk_mem[addr_reg] <= hamming(new_byte);
		end
	end
endmodule

//--- tb/secure_row_ctrl_asserts.sv
// Port checker for the secure row controller
`timescale 1ns/1ps
module secure_row_ctrl_asserts (
	input wire logic mclk, // Clock
	input wire logic resetn, // Reset, active low
	input wire logic ram_parity_err, // RAM parity
	input wire logic rom_parity_err, // ROM parity
	input wire logic [15:0] hw_cfg, // Fuse copy
	input wire logic [1:0] cpu_mode, // Mode
	input wire logic super_mode, // Super level
	input wire logic app_start_ok, // App start
	input wire logic parity_reset, // Reset request
	input wire logic irq // Interrupt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Mode and integrity checks
	// ----------------------------------------
	boot_exit_a: assert property ((cpu_mode == 2'h0) ##1 (cpu_mode != 2'h0)
		|-> cpu_mode inside {2'h1, 2'h2})
		else $error("Boot left into a wrong mode");
	no_boot_ret_a: assert property (cpu_mode != 2'h0 |=> cpu_mode != 2'h0)
		else $error("Boot mode entered again");
	no_test_entry_a: assert property (cpu_mode[1] |=> cpu_mode != 2'h1)
		else $error("Test mode entered late");
	boot_no_app_a: assert property (cpu_mode == 2'h0 |-> !app_start_ok)
		else $error("Application start during boot");
	app_exit_a: assert property (cpu_mode == 2'h3 |=> cpu_mode[1])
		else $error("Application left to wrong mode");
	super_level_a: assert property (super_mode == (cpu_mode != 2'h3))
		else $error("Super level flag wrong");
	parity_rst_a: assert property ((ram_parity_err || rom_parity_err) |=> parity_reset)
		else $error("Parity error without reset");
	cfg_hold_a: assert property ((cpu_mode != 2'h0) ##1 (cpu_mode != 2'h0)
		|-> $stable(hw_cfg))
		else $error("Fuse copy changed after boot");
	// Main scenarios
	cover property (cpu_mode == 2'h0 ##1 cpu_mode == 2'h1);
	cover property (cpu_mode == 2'h2 ##1 cpu_mode == 2'h3);
	cover property (irq);
	cover property (parity_reset);
endmodule
bind secure_row_ctrl secure_row_ctrl_asserts u_chk (.mclk, .resetn, .ram_parity_err,
	.rom_parity_err, .hw_cfg, .cpu_mode, .super_mode, .app_start_ok, .parity_reset, .irq);

//--- tb/secure_row_ctrl_test.sv
// Self-checking bench of the secure row controller
`timescale 1ns/1ps
`include "secure_row_defs.vh"
module secure_row_ctrl_test;
	logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, test_req = 1, boot_done = 0;
	logic ram_parity_err = 0, rom_parity_err = 0, pready, pslverr, super_mode, app_start_ok;
	logic parity_reset, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [15:0] fuse_crc_ref, hw_cfg, fuse_data, fx, fc;
	logic [15:0] fuse[8];
	logic [2:0] fuse_idx;
	logic [1:0] cpu_mode;
	logic [7:0] v;
	logic [7:0] mdl[int];
	logic [11:0] ad[5] = '{12'he00, 12'he20, 12'he30, 12'he50, 12'h100};
	int fail_count = 0, check_count = 0;
	assign fuse_data = fuse[fuse_idx];
	secure_row_ctrl u_secure_row_ctrl (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ram_parity_err, .rom_parity_err, .test_req, .boot_done,
		.fuse_crc_ref, .fuse_data, .fuse_idx, .hw_cfg, .cpu_mode, .super_mode, .app_start_ok,
		.parity_reset, .irq);
	// Clock
	initial forever #25 mclk = ~mclk;
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk) penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		r = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task rd(input logic [11:0] a);
		apb(0, a, 0);
		apb(0, a, 0);
	endtask
	task mem(input logic w, input logic [11:0] a, input logic [7:0] d);
		apb(1, `OFF_ADDR, {20'h0, a});
		if (w) apb(1, `OFF_WDATA, {24'h0, d});
		apb(1, `OFF_CMD, w ? 32'h2 : 32'h1);
		if (!w) rd(`OFF_RDATA);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task mt(input logic [11:0] a);
		mem(0, a, 0);
		chk("byte", {24'h0, mdl[a]}, {24'h0, r[7:0]});
	endtask
	task results;
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Watchdog
	initial begin
		#1000000;
		fail_count++;
		results();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'ha7d0));
		fx = 0;
		fc = `CRC_INIT;
		foreach (fuse[i]) begin
			fuse[i] = 16'($urandom);
			fx ^= fuse[i];
			fc ^= fuse[i];
			repeat (16) fc = fc[15] ? ((fc << 1) ^ `CRC_POLY) : (fc << 1);
		end
		// Wrong reference on first boot, right one after the later reset
		fuse_crc_ref = ~fc;
		repeat (3) @(posedge mclk);
		resetn <= 1;
		boot_done <= 1;
		for (int i = 0; i < 200 && cpu_mode === `MODE_BOOT; i++) @(posedge mclk);
		chk("mode", `MODE_TEST, cpu_mode);
		chk("hwcfg", fx, hw_cfg);
		rd(`OFF_STAT);
		chk("crcerr", 1, r[3]);
		rd(`OFF_CRC);
		chk("crc", {16'h0, fc}, r);
		rd(12'h040);
		chk("unmapped", 0, r);
		foreach (ad[i]) begin
			mdl[ad[i]] = (i == 2) ? 8'h0f : 8'($urandom);
			mem(1, ad[i], mdl[ad[i]]);
		end
		apb(1, `OFF_MODE, 0);
		chk("mode", `MODE_TEST, cpu_mode);
		apb(1, `OFF_MODE, 2);
		chk("mode", `MODE_FW, cpu_mode);
		apb(1, `OFF_CTRL, 32'h2);
		apb(1, `OFF_MODE, 1);
		chk("mode", `MODE_FW, cpu_mode);
		apb(1, `OFF_MODE, 0);
		chk("mode", `MODE_FW, cpu_mode);
		apb(1, `OFF_MASK, 32'h2);
		apb(1, `OFF_STAT, 32'hf);
		apb(1, `OFF_MODE, 3);
		chk("mode", `MODE_APP, cpu_mode);
		chk("super", 0, super_mode);
		mem(1, 12'he00, ~mdl[12'he00]);
		mt(12'he00);
		chk("irq", 1, irq);
		apb(1, `OFF_STAT, 32'h2);
		chk("irq", 0, irq);
		v = 8'($urandom);
		mdl[12'he20] = v;
		mem(1, 12'he20, v);
		mt(12'he20);
		apb(1, `OFF_CTRL, 32'h3);
		mem(1, 12'he20, ~v);
		mt(12'he20);
		mdl[12'he30] = 8'h3f;
		mem(1, 12'he30, 8'h3f);
		mt(12'he30);
		mem(1, 12'he30, 8'h00);
		mt(12'he30);
		apb(1, `OFF_STAT, 32'h2);
		mem(0, 12'he50, 0);
		chk("hidden", 0, r);
		rd(`OFF_STAT);
		chk("deny", 1, r[1]);
		mem(1, 12'he50, ~mdl[12'he50]);
		apb(1, `OFF_MODE, 2);
		mt(12'he50);
		apb(1, `OFF_MODE, 3);
		mdl[12'h100] = v;
		mem(1, 12'h100, v);
		mt(12'h100);
		u_secure_row_ctrl.nvm_mem[12'h100] ^= 8'h10; // One stored bit upset
		mt(12'h100);
		rd(`OFF_STAT);
		chk("corr", 1, r[0]);
		chk("start", 1, app_start_ok);
		apb(1, `OFF_CTRL, 32'h7);
		chk("start", 0, app_start_ok);
		apb(1, `OFF_CTRL, 32'hf);
		r = 0;
		for (int i = 0; i < 1000 && r[2] !== 1'b1; i++) rd(`OFF_STAT);
		chk("erased", 1, r[2]);
		mdl[12'h100] = 0;
		mt(12'h100);
		mt(12'he20);
		ram_parity_err <= 1;
		@(posedge mclk) ram_parity_err <= 0;
		@(negedge mclk) chk("parity", 1, parity_reset);
		@(posedge mclk) rom_parity_err <= 1;
		@(posedge mclk) rom_parity_err <= 0;
		@(negedge mclk) chk("parity", 1, parity_reset);
		@(posedge mclk) resetn <= 0;
		fuse_crc_ref <= fc;
		repeat (3) @(posedge mclk);
		chk("mode", `MODE_BOOT, cpu_mode);
		// Reboot after delivery and card-disable
		resetn <= 1;
		for (int i = 0; i < 200 && cpu_mode === `MODE_BOOT; i++) @(posedge mclk);
		chk("mode", `MODE_FW, cpu_mode);
		chk("start", 0, app_start_ok);
		rd(`OFF_STAT);
		chk("crcerr", 0, r[3]);
		results();
	end
endmodule
